// file: ext_mem_width_adapter.v
`timescale 1ns/1ps
`default_nettype none
`include "ext_mem_width_adapter_defines.vh"

module ext_mem_width_adapter #(
  parameter AW = 20,
  parameter FIFO_DEPTH = 16,
  parameter MCLK_DIV = 2
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Internal request port
  input wire req_valid,
  output wire req_ready,
  input wire req_write,
  input wire req_size32,
  input wire [AW-1:0] req_addr,
  input wire [31:0] req_wdata,
  // Read answer
  output reg rsp_valid,
  output reg [31:0] rsp_rdata,
  // Configuration
  input wire [1:0] mem_width,
  input wire mem_type,
  input wire [3:0] strobe_cycles,
  input wire cs_hold_enable,
  input wire burst_enable,
  // External memory pins
  output reg [AW-1:0] ext_addr,
  output reg [31:0] ext_dout,
  output reg ext_dout_oe,
  input wire [31:0] ext_din,
  output reg ext_cs_n,
  output reg ext_we_n,
  output reg ext_oe_n,
  output reg ext_burst
);

  localparam PKW = 32 + AW + `PK_EXTRA;
  localparam DW = (MCLK_DIV > 1) ? $clog2(MCLK_DIV) : 1;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function [2:0] beats_for;
    input size32;
    input [1:0] width;
    begin
      case (width)
        `EXT_W16: beats_for = size32 ? `BEATS2 : `BEATS1;
        `EXT_W8: beats_for = size32 ? `BEATS4 : `BEATS2;
        default: beats_for = `BEATS1;
      endcase
    end
  endfunction

  function [31:0] low_word;
    input [31:0] data;
    input [1:0] width;
    begin
      case (width)
        `EXT_W16: low_word = data & `MASK16;
        `EXT_W8: low_word = data & `MASK8;
        default: low_word = data;
      endcase
    end
  endfunction

  function [31:0] shift_down;
    input [31:0] data;
    input [1:0] width;
    begin
      case (width)
        `EXT_W16: shift_down = {16'h0000, data[31:16]};
        `EXT_W8: shift_down = {8'h00, data[31:8]};
        default: shift_down = `ZERO32;
      endcase
    end
  endfunction

  function [31:0] place;
    input [31:0] din;
    input [1:0] width;
    input [1:0] beat;
    reg [31:0] w;
    begin
      w = low_word(din, width);
      case (width)
        `EXT_W16: place = (beat == `BEAT0) ? w : {w[15:0], 16'h0000};
        `EXT_W8: place = w << {beat, 3'h0};
        default: place = w;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bridge: request FIFO plus issue spacing

  wire [PKW-1:0] push_word;
  wire [PKW-1:0] op_word;
  wire op_valid;
  wire op_take;
  wire [31:0] req_data_ext;
  reg [1:0] space_cnt;
  reg op_seen;
  reg [2:0] state;

  assign req_data_ext = req_size32 ? req_wdata : (req_wdata & `MASK16);
  assign push_word = {req_write, req_size32, req_addr, req_data_ext};

  ext_mem_fifo #(
    .WIDTH(PKW),
    .DEPTH(FIFO_DEPTH)
  ) u_bridge_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(push_word),
    .out_valid(op_valid),
    .out_ready(op_take),
    .out_data(op_word)
  );

  assign op_take = op_valid & op_seen & (state == `ST_IDLE) & (space_cnt == 2'h0);

  // A fresh entry rests one cycle at the bridge output; a streaming entry is already seen
  always @(posedge clk)
  begin
    op_seen <= op_valid & ~sys_rst;
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      space_cnt <= 2'h0;
    end
    else if (op_take)
    begin
      space_cnt <= `SPACE_RELOAD;
    end
    else if (space_cnt != 2'h0)
    begin
      space_cnt <= space_cnt - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory clock enable

  reg [DW-1:0] div_cnt;
  reg mem_tick;

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      div_cnt <= {DW{1'b0}};
      mem_tick <= 1'b0;
    end
    else if (div_cnt == MCLK_DIV[DW-1:0] - {{(DW-1){1'b0}}, 1'b1} || MCLK_DIV < 2)
    begin
      div_cnt <= {DW{1'b0}};
      mem_tick <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + {{(DW-1){1'b0}}, 1'b1};
      mem_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Split engine

  reg op_write;
  reg [1:0] op_width;
  reg op_hold;
  reg [31:0] shreg;
  reg [31:0] rd_acc;
  reg [1:0] beat;
  reg [2:0] beats_total;
  reg [3:0] strobe_left;
  wire [31:0] rd_next;
  wire last_beat;
  wire [AW-1:0] op_addr;
  wire [31:0] op_data;
  wire [2:0] op_beats;
  wire op_is_write;

  assign op_addr = op_word[`PK_ADDR_LSB +: AW];
  assign op_data = op_word[`PK_DATA_LSB +: 32];
  assign op_is_write = op_word[PKW-1];
  assign op_beats = beats_for(op_word[PKW-2], mem_width);
  assign rd_next = rd_acc | place(ext_din, op_width, beat);
  assign last_beat = ({1'b0, beat} + 3'h1) == beats_total;

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      state <= `ST_IDLE;
      op_write <= 1'b0;
      op_width <= `EXT_W32;
      op_hold <= 1'b0;
      shreg <= `ZERO32;
      rd_acc <= `ZERO32;
      beat <= `BEAT0;
      beats_total <= `BEATS1;
      strobe_left <= `STROBE_ZERO;
      rsp_valid <= 1'b0;
      rsp_rdata <= `ZERO32;
      ext_addr <= {AW{1'b0}};
      ext_dout <= `ZERO32;
      ext_dout_oe <= 1'b0;
      ext_cs_n <= 1'b1;
      ext_we_n <= 1'b1;
      ext_oe_n <= 1'b1;
      ext_burst <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      case (state)
        `ST_IDLE:
        begin
          if (op_take)
          begin
            beats_total <= op_beats;
            op_write <= op_is_write;
            // A 16-bit access keeps only the low half, even on a wide memory
            op_width <= (op_word[PKW-2] | (op_beats != `BEATS1)) ? mem_width : `EXT_W16;
            op_hold <= (mem_type == `MEM_SDRAM) ? burst_enable : cs_hold_enable;
            shreg <= op_data;
            rd_acc <= `ZERO32;
            beat <= `BEAT0;
            strobe_left <= strobe_cycles;
            ext_addr <= op_addr;
            ext_dout <= low_word(op_data, mem_width);
            ext_dout_oe <= op_is_write;
            ext_cs_n <= 1'b0;
            ext_we_n <= ~op_is_write;
            ext_oe_n <= op_is_write;
            ext_burst <= (mem_type == `MEM_SDRAM) & burst_enable & (op_beats != `BEATS1);
            state <= `ST_BEAT;
          end
        end
        `ST_BEAT:
        begin
          if (mem_tick)
          begin
            if (strobe_left != `STROBE_ZERO)
            begin
              strobe_left <= strobe_left - `STROBE_ONE;
            end
            else if (last_beat)
            begin
              ext_cs_n <= 1'b1;
              ext_we_n <= 1'b1;
              ext_oe_n <= 1'b1;
              ext_dout_oe <= 1'b0;
              ext_burst <= 1'b0;
              rsp_valid <= ~op_write;
              rsp_rdata <= rd_next;
              state <= `ST_IDLE;
            end
            else
            begin
              rd_acc <= rd_next;
              beat <= beat + `BEAT1;
              strobe_left <= strobe_cycles;
              ext_addr <= ext_addr + {{(AW-1){1'b0}}, 1'b1};
              shreg <= shift_down(shreg, op_width);
              ext_dout <= low_word(shift_down(shreg, op_width), op_width);
              if (!op_hold)
              begin
                ext_cs_n <= 1'b1;
                ext_we_n <= 1'b1;
                ext_oe_n <= 1'b1;
                state <= `ST_GAP;
              end
            end
          end
        end
        `ST_GAP:
        begin
          // Released select stays high for one memory clock between words
          if (mem_tick)
          begin
            ext_cs_n <= 1'b0;
            ext_we_n <= ~op_write;
            ext_oe_n <= op_write;
            state <= `ST_BEAT;
          end
        end
        default:
        begin
          state <= `ST_IDLE;
        end
      endcase
    end
  end

endmodule // ext_mem_width_adapter

`default_nettype wire

// file: ext_mem_width_adapter_defines.vh
`ifndef EXT_MEM_WIDTH_ADAPTER_DEFINES_VH
`define EXT_MEM_WIDTH_ADAPTER_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// External memory word size codes
`define EXT_W32 2'h0
`define EXT_W16 2'h1
`define EXT_W8 2'h2

// External memory type codes
`define MEM_ASYNC 1'h0
`define MEM_SDRAM 1'h1

////////////////////////////////////////////////////////////////////////////////
// Bridge timing, in system clock cycles
`define SYNC_ISO_CYC 3
`define SYNC_PIPE_CYC 2
`define SPACE_RELOAD 2'h1

////////////////////////////////////////////////////////////////////////////////
// Packed request word: {write, size32, addr, wdata}
`define PK_DATA_LSB 0
`define PK_ADDR_LSB 32
`define PK_EXTRA 2

////////////////////////////////////////////////////////////////////////////////
// Engine states, one-hot
`define ST_IDLE 3'h1
`define ST_BEAT 3'h2
`define ST_GAP 3'h4

// Misc constants
`define ZERO32 32'h00000000
`define MASK8 32'h000000FF
`define MASK16 32'h0000FFFF
`define MASK32 32'hFFFFFFFF
`define BEATS1 3'h1
`define BEATS2 3'h2
`define BEATS4 3'h4
`define BEAT0 2'h0
`define BEAT1 2'h1
`define STROBE_ZERO 4'h0
`define STROBE_ONE 4'h1

`endif

// file: ext_mem_fifo.v
`timescale 1ns/1ps
`default_nettype none

module ext_mem_fifo #(
  parameter WIDTH = 54,
  parameter DEPTH = 16
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Filling side
  input wire in_valid,
  output reg in_ready,
  input wire [WIDTH-1:0] in_data,
  // Draining side
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);

  localparam PW = $clog2(DEPTH);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PW-1:0] wr_ptr;
  reg [PW-1:0] rd_ptr;
  reg [PW:0] count;
  wire push;
  wire pop_mem;
  wire [PW:0] next_count;

  assign push = in_valid & in_ready;
  // Output register refills as soon as it is free or being taken
  assign pop_mem = (count != {(PW+1){1'b0}}) & (~out_valid | out_ready);
  assign next_count = count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop_mem};

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_ptr <= {PW{1'b0}};
      rd_ptr <= {PW{1'b0}};
      count <= {(PW+1){1'b0}};
      in_ready <= 1'b0;
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end
    else
    begin
      count <= next_count;
      // Registered full flag keeps in_ready a flop output
      in_ready <= (next_count != DEPTH[PW:0]);
      if (push)
      begin
        wr_ptr <= wr_ptr + {{(PW-1){1'b0}}, 1'b1};
      end
      if (pop_mem)
      begin
        out_data <= mem[rd_ptr];
        rd_ptr <= rd_ptr + {{(PW-1){1'b0}}, 1'b1};
        out_valid <= 1'b1;
      end
      else if (out_ready)
      begin
        out_valid <= 1'b0;
      end
    end
  end

endmodule // ext_mem_fifo

`default_nettype wire

// file: ext_mem_width_adapter_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "ext_mem_width_adapter_defines.vh"
module ext_mem_width_adapter_chk #(
  parameter AW = 20,
  parameter MCLK_DIV = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Request and read answer side
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic rsp_valid,
  // Configuration
  input wire logic [1:0] mem_width,
  input wire logic mem_type,
  input wire logic [3:0] strobe_cycles,
  input wire logic cs_hold_enable,
  input wire logic burst_enable,
  // Memory pins
  input wire logic [AW-1:0] ext_addr,
  input wire logic [31:0] ext_dout,
  input wire logic ext_dout_oe,
  input wire logic ext_cs_n,
  input wire logic ext_we_n,
  input wire logic ext_oe_n,
  input wire logic ext_burst
);
  logic [3:0] quiet;
  logic [7:0] run;
  logic mid;
  logic cs_q;
  logic [AW-1:0] prev_addr;
  wire take = req_valid && req_ready;
  wire step = ext_addr != prev_addr;
  wire [31:0] keep = (mem_width == `EXT_W16) ? `MASK16 : (mem_width == `EXT_W8) ? `MASK8 : `MASK32;
  // Only takes into an empty bridge are timed; a busy engine hides the latency
  always @(posedge clk)
  begin
    prev_addr <= ext_addr;
    cs_q <= ext_cs_n;
    run <= step ? 8'h01 : run + 8'h01;
    mid <= !ext_cs_n && (mid || (step && !cs_q));
    quiet <= (take || !ext_cs_n) ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
    if (sys_rst)
    begin
      quiet <= 4'hF;
      mid <= 1'b0;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_iso_latency: assert property (take && quiet > 4'h7 |-> ext_cs_n [*4] ##1 !ext_cs_n)
    else $error("idle start latency wrong");
  a_zero_ext: assert property (ext_dout_oe |-> (ext_dout & ~keep) == `ZERO32)
    else $error("data above memory word not zero");
  a_addr_step: assert property (!ext_cs_n && !cs_q && step |-> ext_addr == prev_addr + 1'b1)
    else $error("address step not one word");
  a_select_release: assert property (!mem_type && !cs_hold_enable && !cs_q && step |-> ext_cs_n)
    else $error("select kept low with hold off");
  a_burst_mark: assert property (ext_burst |-> mem_type == `MEM_SDRAM && burst_enable)
    else $error("burst mark outside burst mode");
  a_strobe_len: assert property (!mem_type && mid && step && !ext_cs_n |->
    run == (strobe_cycles + 8'h01) * MCLK_DIV)
    else $error("word length wrong");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("read answer longer than one cycle");
  a_write_drive: assert property (!ext_we_n |-> ext_dout_oe && !ext_cs_n && ext_oe_n)
    else $error("write strobe without data drive");
  c_full: cover property (req_valid && !req_ready);
  c_burst: cover property (ext_burst);
  c_byte_read: cover property (rsp_valid && mem_width == `EXT_W8);
endmodule // ext_mem_width_adapter_chk
bind ext_mem_width_adapter ext_mem_width_adapter_chk #(.AW(AW), .MCLK_DIV(MCLK_DIV)) chk (
  .clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .mem_width(mem_width), .mem_type(mem_type), .strobe_cycles(strobe_cycles), .cs_hold_enable(cs_hold_enable),
  .burst_enable(burst_enable), .ext_addr(ext_addr), .ext_dout(ext_dout), .ext_dout_oe(ext_dout_oe),
  .ext_cs_n(ext_cs_n), .ext_we_n(ext_we_n), .ext_oe_n(ext_oe_n), .ext_burst(ext_burst)
);
`default_nettype wire

// file: ext_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  // Clock
  input wire logic clk,
  // Memory pins
  input wire logic [19:0] ext_addr,
  input wire logic [31:0] ext_dout,
  input wire logic ext_dout_oe,
  input wire logic ext_cs_n,
  input wire logic ext_we_n,
  input wire logic ext_oe_n,
  output wire logic [31:0] ext_din
);
  logic [31:0] mem [0:255];
  logic [31:0] last = 32'h00000000;
  wire rd = !ext_cs_n && !ext_oe_n;
  always @(posedge clk)
  begin
    if (!ext_cs_n && !ext_we_n && ext_dout_oe)
      mem[ext_addr[7:0]] <= ext_dout;
    if (rd)
      last <= ext_din;
  end
  // Released bus shows the inverse of the last word, so a stale sample cannot pass
  assign ext_din = rd ? mem[ext_addr[7:0]] : ~last;
endmodule // ext_mem_model
`default_nettype wire

// file: tb_ext_mem_width_adapter.sv
`timescale 1ns/1ps
`default_nettype none
`include "ext_mem_width_adapter_defines.vh"
module tb_ext_mem_width_adapter;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic req_size32 = 1'b0;
  logic [19:0] req_addr = 20'h00000;
  logic [31:0] req_wdata = 32'h00000000;
  logic [1:0] mem_width = `EXT_W32;
  logic mem_type = `MEM_ASYNC;
  logic [3:0] strobe_cycles = 4'h0;
  logic cs_hold_enable = 1'b1;
  logic burst_enable = 1'b0;
  wire req_ready, rsp_valid, ext_dout_oe, ext_cs_n, ext_we_n, ext_oe_n, ext_burst;
  wire [19:0] ext_addr;
  wire [31:0] rsp_rdata, ext_dout, ext_din;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int stalls = 0;
  always #12.5 clk = ~clk;
  ext_mem_width_adapter uut (
    .clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_size32(req_size32), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .mem_width(mem_width), .mem_type(mem_type), .strobe_cycles(strobe_cycles),
    .cs_hold_enable(cs_hold_enable), .burst_enable(burst_enable), .ext_addr(ext_addr), .ext_dout(ext_dout),
    .ext_dout_oe(ext_dout_oe), .ext_din(ext_din), .ext_cs_n(ext_cs_n), .ext_we_n(ext_we_n),
    .ext_oe_n(ext_oe_n), .ext_burst(ext_burst)
  );
  ext_mem_model mem_i (
    .clk(clk), .ext_addr(ext_addr), .ext_dout(ext_dout), .ext_dout_oe(ext_dout_oe), .ext_din(ext_din),
    .ext_cs_n(ext_cs_n), .ext_we_n(ext_we_n), .ext_oe_n(ext_oe_n)
  );
  ////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Request held until taken; valid is left high so back-to-back puts never glitch it
  task automatic put(input logic w, input logic s32, input logic [19:0] a, input logic [31:0] d);
    req_valid <= 1'b1;
    req_write <= w;
    req_size32 <= s32;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk);
    while (req_ready !== 1'b1)
    begin
      stalls++;
      @(posedge clk);
    end
  endtask
  task automatic settle;
    int q;
    q = 0;
    while (q < 12)
    begin
      @(posedge clk);
      q = (ext_cs_n === 1'b1) ? q + 1 : 0;
    end
  endtask
  task automatic t_writes;
    int b;
    logic [31:0] m;
    for (int c = 0; c < 4; c++)
    begin
      b = (c == 0) ? 32 : (c == 3) ? 8 : 16;
      m = (b == 32) ? `MASK32 : (b == 16) ? `MASK16 : `MASK8;
      mem_width <= (b == 32) ? `EXT_W32 : (b == 16) ? `EXT_W16 : `EXT_W8;
      cs_hold_enable <= (c != 1);
      strobe_cycles <= 4'(c);
      @(posedge clk);
      put(1'b1, 1'b1, 20'(16 * c), 32'h12345678);
      put(1'b1, 1'b0, 20'(16 * c + 8), 32'hABCD1234);
      req_valid <= 1'b0;
      settle();
      for (int i = 0; i < 32 / b; i++)
        check("wr32", mem_i.mem[16 * c + i], (32'h12345678 >> (i * b)) & m);
      for (int i = 0; i < 16 / b + b / 32; i++)
        check("wr16", mem_i.mem[16 * c + 8 + i], (32'h00001234 >> (i * b)) & m);
    end
  endtask
  task automatic rd(input logic s32, input logic [31:0] exp);
    int n;
    n = 0;
    put(1'b0, s32, 20'h00040, 32'h00000000);
    req_valid <= 1'b0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ext_cs_n === 1'b1 && n < 50);
    // Seen one edge after it is set, so three cycles read as four
    check("start", n, 4);
    while (rsp_valid !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    check("rdata", rsp_rdata, exp);
  endtask
  task automatic t_reads;
    logic [31:0] e32 [0:3] = '{32'h5A5A1111, 32'h33331111, 32'h77553311, 32'h77553311};
    logic [31:0] e16 [0:3] = '{32'h00001111, 32'h00001111, 32'h00003311, 32'h00003311};
    for (int i = 0; i < 4; i++)
      mem_i.mem[64 + i] = 32'h5A5A1111 + i * 32'h2222;
    for (int c = 0; c < 4; c++)
    begin
      mem_width <= (c == 0) ? `EXT_W32 : (c == 1) ? `EXT_W16 : `EXT_W8;
      mem_type <= (c == 3);
      burst_enable <= (c == 3);
      settle();
      rd(1'b1, e32[c]);
      settle();
      rd(1'b0, e16[c]);
    end
  endtask
  // block of 32-bit writes fills the queue
  task automatic t_stream;
    mem_type <= `MEM_ASYNC;
    mem_width <= `EXT_W16;
    strobe_cycles <= 4'h7;
    settle();
    stalls = 0;
    for (int k = 0; k < 20; k++)
      put(1'b1, 1'b1, 20'(128 + 2 * k), {16'hB000 + k[15:0], 16'hA000 + k[15:0]});
    req_valid <= 1'b0;
    check("refused", stalls > 0, 1);
    settle();
    for (int k = 0; k < 20; k++)
    begin
      check("lo", mem_i.mem[128 + 2 * k], 32'hA000 + k);
      check("hi", mem_i.mem[129 + 2 * k], 32'hB000 + k);
    end
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_writes();
    t_reads();
    t_stream();
    tally_and_finish();
  end
endmodule // tb_ext_mem_width_adapter
`default_nettype wire
